// >>> rtl/pcl_pkg.sv
// Purpose: shared constants and types of the parallel configuration load port
// Assumes: 250 MHz system clock on both ends
// Notes:   times are kept in ns (clock period in ps), cycle counts are derived from them
package pcl_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS         = 4000;
    localparam int unsigned REQ_LOW_MIN_NS        = 2000;
    localparam int unsigned STATUS_LOW_MIN_NS     = 268000;
    localparam int unsigned REQ_HIGH_TO_CLK_NS    = 1506000;
    localparam int unsigned STATUS_HIGH_TO_CLK_NS = 2000;
    localparam int unsigned INIT_OSC_MIN_NS       = 175000;
    localparam int unsigned POR_DELAY_NS          = 100000;
    localparam int unsigned CFG_CLK_MAX_PERIOD_NS = 10;
    localparam int unsigned DONE_TO_UCLK_PERIODS  = 4;
    localparam int unsigned USER_INIT_PERIODS     = 8576;
    localparam int unsigned TAIL_EDGES            = 2;

    // least times round up to whole cycles
    function automatic int unsigned ns2cyc(input int unsigned ns);
        return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    localparam int unsigned REQ_LOW_CYCLES        = ns2cyc(REQ_LOW_MIN_NS);
    localparam int unsigned STATUS_LOW_CYCLES     = ns2cyc(STATUS_LOW_MIN_NS);
    localparam int unsigned REQ_HIGH_TO_CLK_CYC   = ns2cyc(REQ_HIGH_TO_CLK_NS);
    localparam int unsigned STATUS_TO_CLK_CYCLES  = ns2cyc(STATUS_HIGH_TO_CLK_NS);
    localparam int unsigned INIT_OSC_CYCLES       = ns2cyc(INIT_OSC_MIN_NS);
    localparam int unsigned POR_CYCLES            = ns2cyc(POR_DELAY_NS);
    localparam int unsigned DONE_TO_UCLK_CYCLES   =
        ns2cyc(DONE_TO_UCLK_PERIODS * CFG_CLK_MAX_PERIOD_NS);

    // ------------------------------------------------------------
    // link shape
    // ------------------------------------------------------------
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned FIFO_DEPTH   = 32;
    localparam int unsigned IMAGE_WORDS  = 64;
    localparam int unsigned WORD_CNT_W   = 16;
    localparam int unsigned CNT_W        = 20;
    localparam int unsigned USR_CNT_W    = 14;
    localparam int unsigned BEAT_W       = 3;
    localparam int unsigned RATIO_GT1    = 4;
    localparam int unsigned CFG_CLK_HALF = 2;
    localparam int unsigned USR_CLK_HALF = 4;
    localparam int unsigned OPT_INIT_DONE_BIT = 0;
    localparam int unsigned OPT_USER_CLK_BIT  = 1;

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PCL_DEV_POR   = 3'h0,
        PCL_DEV_CLEAR = 3'h1,
        PCL_DEV_LOAD  = 3'h3,
        PCL_DEV_INIT  = 3'h2,
        PCL_DEV_USER  = 3'h6
    } pcl_dev_state_t;

    typedef enum logic [2:0] {
        PCL_HST_IDLE   = 3'h0,
        PCL_HST_REQ    = 3'h1,
        PCL_HST_WAITST = 3'h3,
        PCL_HST_GAP    = 3'h2,
        PCL_HST_STREAM = 3'h6,
        PCL_HST_TAIL   = 3'h7,
        PCL_HST_PARK   = 3'h5
    } pcl_hst_state_t;
endpackage

// >>> rtl/pcl_link_if.sv
// Purpose: pin bundle between configuration host and device
// Assumes: open-drain lines have board pull-ups
// Notes:   wired levels are resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface pcl_link_if;
    import pcl_pkg::*;
    logic              cfgReq_n;
    logic              configClock;
    logic              userInitClock;
    logic [DATA_W-1:0] data;
    logic              devStatusOe;
    logic              hostStatusOe;
    logic              devDoneOe;
    logic              devInitDoneOe;
    logic              status;
    logic              done;
    logic              initDone;

    // open drain: any enable pulls low, otherwise pulled high
    assign status   = ~(devStatusOe | hostStatusOe);
    assign done     = ~devDoneOe;
    assign initDone = ~devInitDoneOe;

    modport dev (
        input  cfgReq_n, configClock, userInitClock, data,
        output devStatusOe, devDoneOe, devInitDoneOe
    );
    modport host (
        output cfgReq_n, configClock, userInitClock, data, hostStatusOe,
        input  status, done, initDone
    );
endinterface
`default_nettype wire

// >>> rtl/pcl_device.sv
// Purpose: device end of the fast_passive_parallel configuration port
// Assumes: clk stands in for the internal oscillator; configClock from host
// Notes:   image word 0 carries the option bits
`timescale 1ns/1ps
`default_nettype none
module pcl_device #(
    parameter int unsigned POR_CYC    = pcl_pkg::POR_CYCLES,
    parameter int unsigned STATUS_CYC = pcl_pkg::STATUS_LOW_CYCLES,
    parameter int unsigned INIT_CYC   = pcl_pkg::INIT_OSC_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    pcl_link_if.dev                        bus,
    input  wire logic                      decompressEn,
    input  wire logic                      securityEn,
    output logic                           inUserMode,
    output logic [pcl_pkg::DATA_W-1:0]     configSum
);
    import pcl_pkg::*;

    // ------------------------------------------------------------
    // state of both domains
    // ------------------------------------------------------------
    typedef struct packed {
        pcl_dev_state_t       state;
        logic [CNT_W-1:0]     cnt;
        logic [USR_CNT_W-1:0] usrCnt;
        logic [1:0]           reqSync;
        logic [1:0]           cmpSync;
        logic [1:0]           kickSync;
        logic [2:0]           uclkSync;
        logic [1:0]           decSync;
        logic [1:0]           secSync;
        logic                 ratio;
        logic                 loadArm;
        logic                 statusOe;
        logic                 doneOe;
        logic                 initOe;
        logic                 optInit;
        logic                 optUclk;
        logic                 userMode;
    } pcl_dev_core_t;

    typedef struct packed {
        logic [BEAT_W-1:0]     beat;
        logic [WORD_CNT_W-1:0] wordCnt;
        logic                  complete;
        logic [1:0]            tail;
        logic                  kick;
        logic [1:0]            word0;
        logic [DATA_W-1:0]     sum;
    } pcl_dev_link_t;

    // request sync resets to the idle level, else reset looks like a request
    localparam pcl_dev_core_t CORE_RST = '{
        state: PCL_DEV_POR, statusOe: 1'b1, doneOe: 1'b1, reqSync: 2'b11, default: '0};

    pcl_dev_core_t q;
    pcl_dev_core_t d;
    pcl_dev_link_t lq;
    pcl_dev_link_t ld;
    logic          uclkRise;
    logic          ratioGt1;
    logic          lastBeat;

    // ------------------------------------------------------------
    // oscillator domain: reset, status, completion, initialization
    // ------------------------------------------------------------
    assign uclkRise = q.uclkSync[1] & ~q.uclkSync[2];

    always_comb begin
        d          = q;
        d.reqSync  = {q.reqSync[0], bus.cfgReq_n};
        d.cmpSync  = {q.cmpSync[0], lq.complete};
        d.kickSync = {q.kickSync[0], lq.kick};
        d.uclkSync = {q.uclkSync[1:0], bus.userInitClock};
        d.decSync  = {q.decSync[0], decompressEn};
        d.secSync  = {q.secSync[0], securityEn};
        d.cnt      = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
        unique case (q.state)
            PCL_DEV_POR: begin
                if (q.cnt >= CNT_W'(POR_CYC - 1) && q.reqSync[1]) begin
                    d.state    = PCL_DEV_LOAD;
                    d.statusOe = 1'b0;
                    d.loadArm  = 1'b1;
                    d.ratio    = q.decSync[1] | q.secSync[1];
                end
            end
            PCL_DEV_CLEAR: begin
                if (q.cnt >= CNT_W'(STATUS_CYC - 1) && q.reqSync[1]) begin
                    d.state    = PCL_DEV_LOAD;
                    d.statusOe = 1'b0;
                    d.loadArm  = 1'b1;
                    d.ratio    = q.decSync[1] | q.secSync[1];
                end
            end
            PCL_DEV_LOAD: begin
                if (q.cmpSync[1] && q.doneOe) begin
                    d.doneOe  = 1'b0;
                    d.optInit = lq.word0[OPT_INIT_DONE_BIT];
                    d.optUclk = lq.word0[OPT_USER_CLK_BIT];
                    d.initOe  = lq.word0[OPT_INIT_DONE_BIT];
                end
                if (q.kickSync[1] && !q.doneOe) begin
                    d.state  = PCL_DEV_INIT;
                    d.cnt    = '0;
                    d.usrCnt = '0;
                end
            end
            PCL_DEV_INIT: begin
                if (q.optUclk) begin
                    if (q.cnt >= CNT_W'(DONE_TO_UCLK_CYCLES - 1) && uclkRise) begin
                        d.usrCnt = q.usrCnt + 1'b1;
                        // first rise opens the count, so whole periods follow it
                        if (q.usrCnt == USR_CNT_W'(USER_INIT_PERIODS)) begin
                            d.state = PCL_DEV_USER;
                        end
                    end
                end else if (q.cnt >= CNT_W'(INIT_CYC - 1)) begin
                    d.state = PCL_DEV_USER;
                end
                if (d.state == PCL_DEV_USER) begin
                    d.initOe   = 1'b0;
                    d.userMode = 1'b1;
                end
            end
            PCL_DEV_USER: begin
                d.userMode = 1'b1;
            end
            default: begin
                d.state = PCL_DEV_POR;
            end
        endcase
        // request low wins over every state; two sync stages keep this near 12 ns
        if (!q.reqSync[1]) begin
            d.state    = PCL_DEV_CLEAR;
            d.statusOe = 1'b1;
            d.doneOe   = 1'b1;
            d.initOe   = 1'b0;
            d.loadArm  = 1'b0;
            d.userMode = 1'b0;
            if (q.state != PCL_DEV_CLEAR) begin
                d.cnt = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // link domain: word capture on configClock
    // ------------------------------------------------------------
    // reset is released while configClock is still parked, since the host
    // waits microseconds after status rises before its first edge
    // latched at load start; link side sits in reset whenever it may change
    assign ratioGt1 = q.ratio;
    assign lastBeat = ratioGt1 ? (lq.beat == BEAT_W'(RATIO_GT1 - 1)) : 1'b1;

    always_comb begin
        ld         = lq;
        if (!lq.complete) begin
            ld.beat = lastBeat ? '0 : lq.beat + 1'b1;
            if (lastBeat) begin
                ld.wordCnt = lq.wordCnt + 1'b1;
                ld.sum     = lq.sum ^ bus.data;
                if (lq.wordCnt == '0) begin
                    ld.word0 = bus.data[1:0];
                end
                if (lq.wordCnt == WORD_CNT_W'(IMAGE_WORDS - 1)) begin
                    ld.complete = 1'b1;
                end
            end
        end else if (!lq.kick) begin
            ld.tail = lq.tail + 1'b1;
            if (lq.tail == 2'(TAIL_EDGES - 1)) begin
                ld.kick = 1'b1;
            end
        end
    end

    always_ff @(posedge bus.configClock or negedge q.loadArm) begin
        if (!q.loadArm) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.devStatusOe   = q.statusOe;
    assign bus.devDoneOe     = q.doneOe;
    assign bus.devInitDoneOe = q.initOe;
    assign inUserMode        = q.userMode;
    assign configSum         = lq.sum;
endmodule // pcl_device
`default_nettype wire

// >>> rtl/pcl_host.sv
// Purpose: host end: drives request, configuration clock and data words
// Assumes: configuration clock is divided down from clk
// Notes:   words come from a local FIFO that the user fills
`timescale 1ns/1ps
`default_nettype none
module pcl_fifo #(
    parameter int unsigned WIDTH = pcl_pkg::DATA_W,
    parameter int unsigned DEPTH = pcl_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             wrValid,
    output logic                  wrReady,
    output logic [WIDTH-1:0]      rdData,
    output logic                  rdValid,
    input  wire logic             rdReady
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } pcl_fifo_st_t;

    pcl_fifo_st_t q;
    pcl_fifo_st_t d;

    assign rdValid = (q.wp != q.rp);
    assign wrReady = (q.wp[AW-1:0] != q.rp[AW-1:0]) || (q.wp[AW] == q.rp[AW]);
    assign rdData  = q.mem[q.rp[AW-1:0]];

    always_comb begin
        d = q;
        if (wrValid && wrReady) begin
            d.mem[q.wp[AW-1:0]] = wrData;
            d.wp                = q.wp + 1'b1;
        end
        if (rdValid && rdReady) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // pcl_fifo

module pcl_host #(
    parameter int unsigned REQ_HIGH_CYC = pcl_pkg::REQ_HIGH_TO_CLK_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    pcl_link_if.host                       bus,
    input  wire logic                      startReq,
    input  wire logic                      monitorStatus,
    input  wire logic                      holdStatus,
    input  wire logic                      ratioGt1,
    input  wire logic [pcl_pkg::DATA_W-1:0] wrData,
    input  wire logic                      wrValid,
    output logic                           wrReady,
    output logic                           busy,
    output logic                           userModeSeen
);
    import pcl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pcl_hst_state_t    state;
        logic [CNT_W-1:0]  cnt;
        logic [1:0]        div;
        logic              clkOut;
        logic [BEAT_W-1:0] beat;
        logic [DATA_W-1:0] word;
        logic              haveWord;
        logic [1:0]        tail;
        logic              req_n;
        logic              holdOe;
        logic [2:0]        uDiv;
        logic              uClk;
        logic [1:0]        stSync;
        logic [1:0]        dnSync;
        logic [1:0]        idSync;
        logic              busy;
        logic              userSeen;
    } pcl_hst_st_t;

    localparam pcl_hst_st_t HST_RST = '{
        state: PCL_HST_IDLE, req_n: 1'b1, default: '0};

    pcl_hst_st_t       q;
    pcl_hst_st_t       d;
    logic              popReady;
    logic              popValid;
    logic [DATA_W-1:0] popData;
    logic              divEnd;
    logic              lastBeat;

    pcl_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk     (clk),
        .arst_n  (arst_n),
        .wrData  (wrData),
        .wrValid (wrValid),
        .wrReady (wrReady),
        .rdData  (popData),
        .rdValid (popValid),
        .rdReady (popReady)
    );

    // word fetched only while clock is low and none is held
    assign popReady = (q.state == PCL_HST_STREAM) && !q.clkOut && !q.haveWord;
    assign divEnd   = (q.div == 2'(CFG_CLK_HALF - 1));
    assign lastBeat = ratioGt1 ? (q.beat == BEAT_W'(RATIO_GT1 - 1)) : 1'b1;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        d        = q;
        d.stSync = {q.stSync[0], bus.status};
        d.dnSync = {q.dnSync[0], bus.done};
        d.idSync = {q.idSync[0], bus.initDone};
        d.holdOe = holdStatus;
        d.uDiv   = (q.uDiv == 3'(USR_CLK_HALF - 1)) ? '0 : q.uDiv + 1'b1;
        d.uClk   = (q.uDiv == 3'(USR_CLK_HALF - 1)) ? ~q.uClk : q.uClk;
        d.cnt    = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
        d.div    = divEnd ? '0 : q.div + 1'b1;
        unique case (q.state)
            PCL_HST_IDLE: begin
                if (startReq) begin
                    d.state    = PCL_HST_REQ;
                    d.req_n    = 1'b0;
                    d.cnt      = '0;
                    d.busy     = 1'b1;
                    d.userSeen = 1'b0;
                end
            end
            PCL_HST_REQ: begin
                if (q.cnt >= CNT_W'(REQ_LOW_CYCLES - 1)) begin
                    d.state = PCL_HST_WAITST;
                    d.req_n = 1'b1;
                    d.cnt   = '0;
                end
            end
            PCL_HST_WAITST: begin
                if (monitorStatus && q.stSync[1]) begin
                    d.state = PCL_HST_GAP;
                    d.cnt   = '0;
                end else if (!monitorStatus && q.cnt >= CNT_W'(REQ_HIGH_CYC - 1)) begin
                    d.state = PCL_HST_STREAM;
                end
            end
            PCL_HST_GAP: begin
                if (q.cnt >= CNT_W'(STATUS_TO_CLK_CYCLES - 1)) begin
                    d.state = PCL_HST_STREAM;
                end
            end
            PCL_HST_STREAM: begin
                if (popReady && popValid) begin
                    d.word     = popData;
                    d.haveWord = 1'b1;
                    d.div      = '0; // setup of two cycles before the rise
                end else if (divEnd && q.clkOut) begin
                    d.clkOut = 1'b0;
                    d.beat   = lastBeat ? '0 : q.beat + 1'b1;
                    if (lastBeat) begin
                        d.haveWord = 1'b0;
                    end
                end else if (divEnd && q.haveWord) begin
                    d.clkOut = 1'b1;
                end
                if (q.dnSync[1] && !q.clkOut) begin
                    d.state    = PCL_HST_TAIL;
                    d.tail     = '0;
                    d.haveWord = 1'b0;
                end
            end
            PCL_HST_TAIL: begin
                if (divEnd) begin
                    d.clkOut = ~q.clkOut;
                    if (q.clkOut) begin
                        d.tail = q.tail + 1'b1;
                        if (q.tail == 2'(TAIL_EDGES - 1)) begin
                            d.state = PCL_HST_PARK;
                        end
                    end
                end
            end
            PCL_HST_PARK: begin
                d.clkOut = 1'b0;
                if (q.idSync[1]) begin
                    d.state    = PCL_HST_IDLE;
                    d.busy     = 1'b0;
                    d.userSeen = 1'b1;
                end
            end
            default: begin
                d.state = PCL_HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= HST_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.cfgReq_n      = q.req_n;
    assign bus.configClock   = q.clkOut;
    assign bus.userInitClock = q.uClk;
    assign bus.data          = q.word;
    assign bus.hostStatusOe  = q.holdOe;
    assign busy              = q.busy;
    assign userModeSeen      = q.userSeen;
endmodule // pcl_host
`default_nettype wire

// >>> tb/pcl_properties.sv
// Purpose: link timing checks between the two ends
// Assumes: both ends run on clk, shortened counts handed in
// Notes:   counters stand in for the long waits
`timescale 1ns/1ps
`default_nettype none
module pcl_properties
    import pcl_pkg::*;
#(
    parameter int unsigned POR_CYC      = 20,
    parameter int unsigned STATUS_CYC   = 50,
    parameter int unsigned REQ_HIGH_CYC = 60
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              cfgReq_n,
    input wire logic              configClock,
    input wire logic [DATA_W-1:0] data,
    input wire logic              devStatusOe,
    input wire logic              hostStatusOe,
    input wire logic              status,
    input wire logic              done
);
    int unsigned stLow, stHigh, reqHigh, reqLow, rises;
    logic        reqSeen;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {stLow, stHigh, reqHigh, reqLow, rises, reqSeen} <= '0;
        end else begin
            stLow   <= status ? 0 : stLow + 1;
            stHigh  <= status ? stHigh + 1 : 0;
            reqHigh <= cfgReq_n ? reqHigh + 1 : 0;
            reqLow  <= cfgReq_n ? 0 : reqLow + 1;
            rises   <= !cfgReq_n ? 0 : rises + $rose(configClock);
            reqSeen <= reqSeen | !cfgReq_n;
        end
    end
    a_done_fast: assert property ($fell(cfgReq_n) |-> ##[1:150] !done)
        else $error("done not low in time");
    a_status_fast: assert property ($fell(cfgReq_n) |-> ##[1:150] !status)
        else $error("status not low in time");
    a_status_min: assert property ($rose(status) |-> stLow >= (reqSeen ? STATUS_CYC : POR_CYC))
        else $error("status low too short");
    a_status_free: assert property ($rose(cfgReq_n) && !hostStatusOe |-> ##[1:100] !devStatusOe)
        else $error("status not released");
    a_image_whole: assert property ($rose(done) |-> rises >= IMAGE_WORDS)
        else $error("done before whole image");
    a_clk_start: assert property ($rose(configClock) && !done |->
        stHigh >= STATUS_TO_CLK_CYCLES || reqHigh >= REQ_HIGH_CYC)
        else $error("clock edge too early");
    a_clk_rate: assert property ($rose(configClock) |=> !$rose(configClock) [*2])
        else $error("clock too fast");
    a_data_setup: assert property ($rose(configClock) |-> data == $past(data, 2))
        else $error("data not set up before edge");
    a_req_width: assert property ($rose(cfgReq_n) |-> reqLow >= REQ_LOW_CYCLES)
        else $error("request pulse too short");
    c_reload: cover property ($fell(cfgReq_n) && done);
    c_done: cover property ($rose(done));
    c_held: cover property (hostStatusOe && cfgReq_n && !status);
endmodule // pcl_properties
`default_nettype wire

// >>> tb/pcl_tb.sv
// Purpose: three image loads across the link, host FIFO filled first
// Assumes: shortened counts, both ends on the same clk
// Notes:   second load uses the user init clock, so it is long
`timescale 1ns/1ps
`default_nettype none
module pcl_tb;
    import pcl_pkg::*;
    localparam int unsigned T_POR = 20, T_STATUS = 50, T_INIT = 40, T_REQ_HIGH = 60;
    logic clk = 1'b0, arst_n = 1'b0, startReq = 1'b0, monitorStatus = 1'b0;
    logic holdStatus = 1'b0, ratioGt1 = 1'b0, securityEn = 1'b0, wrValid = 1'b0;
    logic decompressEn = 1'b0;
    logic [DATA_W-1:0] wrData = '0, configSum, sum;
    logic wrReady, busy, userModeSeen, inUserMode;
    int fail_count = 0, n_checks = 0, cyc = 0;
    pcl_link_if bus ();
    pcl_device #(.POR_CYC(T_POR), .STATUS_CYC(T_STATUS), .INIT_CYC(T_INIT)) pcl_device_i (
        .clk(clk), .arst_n(arst_n), .bus(bus), .decompressEn(decompressEn),
        .securityEn(securityEn), .inUserMode(inUserMode), .configSum(configSum));
    pcl_host #(.REQ_HIGH_CYC(T_REQ_HIGH)) pcl_host_i (.clk(clk), .arst_n(arst_n), .bus(bus),
        .startReq(startReq), .monitorStatus(monitorStatus), .holdStatus(holdStatus),
        .ratioGt1(ratioGt1), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
        .busy(busy), .userModeSeen(userModeSeen));
    pcl_properties #(.POR_CYC(T_POR), .STATUS_CYC(T_STATUS), .REQ_HIGH_CYC(T_REQ_HIGH))
        pcl_properties_i (
        .clk(clk), .arst_n(arst_n), .cfgReq_n(bus.cfgReq_n), .configClock(bus.configClock),
        .data(bus.data), .devStatusOe(bus.devStatusOe), .hostStatusOe(bus.hostStatusOe),
        .status(bus.status), .done(bus.done));
    always #2 clk = ~clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // value held until the edge that sees ready high
    task automatic push(input logic [31:0] w);
        int n;
        n = 0;
        @(negedge clk);
        wrData = w;
        wrValid = 1'b1;
        while (wrReady !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check(n < 5000, 1'b1);
        @(posedge clk);
    endtask
    task automatic load(input logic [1:0] opt, input logic rt, input logic mon);
        logic [31:0] w;
        int n, k;
        @(negedge clk);
        {sum, n, k} = '0;
        {ratioGt1, monitorStatus, holdStatus} = {rt, mon, mon};
        {securityEn, decompressEn} = {rt & ~opt[1], rt & opt[1]};
        for (int i = 0; i < IMAGE_WORDS; i++) begin
            w = (i == 0) ? {30'h1696_8000, opt} : 32'h5A00_0000 + i * 32'h0001_0101;
            sum ^= w;
            push(w);
            if (i == FIFO_DEPTH - 1) begin
                @(negedge clk);
                wrValid = 1'b0;
                check(wrReady, 1'b0);
                startReq = 1'b1;
                @(negedge clk);
                startReq = 1'b0;
                repeat (150) @(negedge clk);
                check({bus.status, bus.done, busy}, 3'h1);
                while (mon && bus.cfgReq_n !== 1'b1 && n < 1000) begin
                    @(negedge clk);
                    n++;
                end
                repeat (mon ? 200 : 0) @(negedge clk);
                check(n < 1000, 1'b1);
                check({bus.status, bus.configClock}, 2'b00);
                holdStatus = 1'b0;
            end
        end
        @(negedge clk);
        wrValid = 1'b0;
        check(bus.done, 1'b0);
        n = 0;
        while ((userModeSeen !== 1'b1 || inUserMode !== 1'b1) && k < 90000) begin
            @(negedge clk);
            k++;
            n += (bus.done === 1'b1 && bus.initDone === !opt[0]);
        end
        check(k < 90000, 1'b1);
        check(configSum, sum);
        check({bus.status, bus.done, bus.initDone, bus.cfgReq_n, bus.configClock, busy},
            6'h3C);
        check(n >= (opt[1] ? DONE_TO_UCLK_CYCLES + USER_INIT_PERIODS * USR_CLK_HALF * 2
            : T_INIT), 1'b1);
        $display("test load option %0d done", opt);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check({bus.status, bus.done}, 2'b00);
        $display("test reset done");
        load(2'b01, 1'b0, 1'b1);
        load(2'b10, 1'b1, 1'b0);
        load(2'b00, 1'b1, 1'b1);
        print_verdict();
    end
endmodule // pcl_tb
`default_nettype wire
